// File: hw/aws_pkg.sv
// Constants and carrier types for the area wait-state controller.
`default_nettype none
package aws_pkg;
  // Register byte addresses on the AXI4-Lite slave.
  localparam logic [3:0]  AWS_OFS_WAIT   = 4'h0;
  localparam logic [3:0]  AWS_OFS_MEM    = 4'h4;
  localparam logic [3:0]  AWS_OFS_STAT   = 4'h8;
  localparam int          AWS_AW         = 4;
  localparam logic [15:0] AWS_WAIT_RST   = 16'hffff;
  localparam logic [1:0]  AWS_MEM_RST    = 2'h0;
  // Field positions inside the wait control register.
  localparam int          AWS_A6_LSB     = 13;
  localparam int          AWS_A5_LSB     = 10;
  localparam int          AWS_A4_LSB     = 7;
  localparam int          AWS_A3_LSB     = 5;
  localparam int          AWS_A12_LSB    = 3;
  localparam int          AWS_A0_LSB     = 0;
  // Memory type bits: set means DRAM, SDRAM or pseudo-SRAM.
  localparam int          AWS_MEM_A3_BIT  = 0;
  localparam int          AWS_MEM_A12_BIT = 1;
  // Status layout.
  localparam int          AWS_ST_BUSY    = 0;
  localparam int          AWS_ST_PIN     = 1;
  localparam int          AWS_ST_CNT_LSB = 8;
  // Code tables, entry i belongs to code i.
  localparam logic [7:0][3:0] AWS_FIRST_TBL = {4'ha, 4'h8, 4'h6, 4'h4, 4'h3, 4'h2, 4'h1, 4'h0};
  localparam logic [7:0][3:0] AWS_BURST_TBL = {4'ha, 4'h8, 4'h6, 4'h4, 4'h4, 4'h3, 4'h2, 4'h2};
  localparam logic [3:0][3:0] AWS_CAS_TBL   = {4'h3, 4'h2, 4'h1, 4'h1};
  localparam logic [4:0]  AWS_BASE_STATES = 5'h02;
  localparam logic [1:0]  AWS_RESP_OK    = 2'h0;
  localparam logic [1:0]  AWS_RESP_ERR   = 2'h2;

  typedef struct packed {
    logic [2:0] area;
    logic       burst;
  } aws_req_s;

  typedef struct packed {
    logic [4:0] len_m1;
    logic       honour;
    logic [1:0] cas;
  } aws_dec_s;

  typedef enum logic [1:0] {
    AWS_IDLE   = 2'b00,
    AWS_COUNT  = 2'b01,
    AWS_EXTEND = 2'b11
  } aws_state_e;
endpackage : aws_pkg
`default_nettype wire

// File: hw/aws_wait_decode.sv
// Decoder from the area code fields to a cycle length and wait-pin enable.
`default_nettype none
module aws_wait_decode
  import aws_pkg::*;
(
  input  wire logic [15:0] wait_reg_i,
  input  wire logic [1:0]  mem_reg_i,
  input  wire aws_req_s    req_i,
  output aws_dec_s         dec_o
);
  logic [2:0] code3;
  logic [1:0] code2;
  logic       is_dram;
  logic [4:0] states;

  always_comb begin
    code3   = 3'h0;
    code2   = 2'h0;
    is_dram = 1'b0;
    states  = 5'h00;
    dec_o   = '0;
    case (req_i.area)
      3'd0: code3 = wait_reg_i[AWS_A0_LSB +: 3];
      3'd1, 3'd2: begin
        code2   = wait_reg_i[AWS_A12_LSB +: 2];
        is_dram = mem_reg_i[AWS_MEM_A12_BIT];
      end
      3'd3: begin
        code2   = wait_reg_i[AWS_A3_LSB +: 2];
        is_dram = mem_reg_i[AWS_MEM_A3_BIT];
      end
      3'd4: code3 = wait_reg_i[AWS_A4_LSB +: 3];
      3'd5: code3 = wait_reg_i[AWS_A5_LSB +: 3];
      3'd6: code3 = wait_reg_i[AWS_A6_LSB +: 3];
      default: code3 = 3'h0;
    endcase
    if (req_i.area == 3'd1 || req_i.area == 3'd2 || req_i.area == 3'd3) begin
      if (is_dram) begin
        dec_o.cas    = code2;
        states       = AWS_BASE_STATES + {1'b0, AWS_CAS_TBL[code2]};
        dec_o.honour = 1'b0;
      end else begin
        states       = AWS_BASE_STATES + {3'h0, code2};
        dec_o.honour = (code2 != 2'h0);
      end
    end else if (req_i.burst && (req_i.area inside {3'd0, 3'd5, 3'd6})) begin
      states       = {1'b0, AWS_BURST_TBL[code3]};
      dec_o.honour = 1'b1;
    end else begin
      states       = AWS_BASE_STATES + {1'b0, AWS_FIRST_TBL[code3]};
      dec_o.honour = (code3 != 3'h0);
    end
    dec_o.len_m1 = states - 5'h01;
  end
endmodule : aws_wait_decode
`default_nettype wire

// File: hw/aws_wait_ctrl.sv
// Area wait-state controller with its AXI4-Lite register slave.
// Notes on behaviour
// - Wait control register is 16-bit read/write, loads all ones at power-on reset.
// - Manual reset and standby leave the wait control register unchanged.
// - Bits 15:13 set area 6 first waits 0,1,2,3,4,6,8,10; code 0 ignores pin.
// - Bits 12:10 set area 5 first waits likewise; only code 0 ignores pin.
// - Areas 5 and 6 burst beats take 2,2,3,4,4,6,8,10 states, pin honoured.
// - Bits 9:7 set area 4 waits 0,1,2,3,4,6,8,10; code 0 ignores pin.
// - Area 3 normal memory adds 0 to 3 waits; pin ignored only at code 0.
// - Area 3 DRAM-like memory gets CAS period 1,1,2,3 from its code.
// - Area 3 honours the wait pin only for normal memory.
// - Bits 4:3 control areas 1 and 2; pin ignored for DRAM or SDRAM.
// - Areas 1-2 normal add 0 to 3 waits; DRAM gives CAS 1,1,2,3.
// - Bits 2:0 set area 0 waits and burst pitch like areas 5 and 6.
//
// Implementation choices: the AXI4-Lite register port and the placing of the registers.
`default_nettype none
module aws_wait_ctrl
  import aws_pkg::*;
(
  input  wire logic        clk_sys_i,
  input  wire logic        nrst_i,
  input  wire logic        manual_rst_i,
  input  wire logic        standby_i,
  input  wire logic [31:0] s_awaddr_i,
  input  wire logic        s_awvalid_i,
  output logic             s_awready_o,
  input  wire logic [31:0] s_wdata_i,
  input  wire logic [3:0]  s_wstrb_i,
  input  wire logic        s_wvalid_i,
  output logic             s_wready_o,
  output logic [1:0]       s_bresp_o,
  output logic             s_bvalid_o,
  input  wire logic        s_bready_i,
  input  wire logic [31:0] s_araddr_i,
  input  wire logic        s_arvalid_i,
  output logic             s_arready_o,
  output logic [31:0]      s_rdata_o,
  output logic [1:0]       s_rresp_o,
  output logic             s_rvalid_o,
  input  wire logic        s_rready_i,
  input  wire logic        cycle_start_i,
  input  wire aws_req_s    cycle_req_i,
  input  wire logic        ext_wait_i,
  output logic             cycle_busy_o,
  output logic             cycle_done_o,
  output logic [1:0]       cas_code_o
);
  // Register state.
  logic [15:0]       wait_r, wait_nxt;
  logic [1:0]        mem_r, mem_nxt;
  // AXI write and read channel state.
  logic              aw_have_r, aw_have_nxt;
  logic [AWS_AW-1:0] aw_addr_r, aw_addr_nxt;
  logic              w_have_r, w_have_nxt;
  logic [31:0]       w_data_r, w_data_nxt;
  logic [3:0]        w_strb_r, w_strb_nxt;
  logic              awready_r, awready_nxt;
  logic              wready_r, wready_nxt;
  logic              bvalid_r, bvalid_nxt;
  logic [1:0]        bresp_r, bresp_nxt;
  logic              arready_r, arready_nxt;
  logic              rvalid_r, rvalid_nxt;
  logic [31:0]       rdata_r, rdata_nxt;
  logic [1:0]        rresp_r, rresp_nxt;
  // Wait pin synchroniser.
  logic              pin_s1_r, pin_s2_r, pin_s3_r;
  logic              pin_lvl_r, pin_lvl_nxt;
  // Cycle sequencer.
  aws_state_e        st_r, st_nxt;
  logic [4:0]        cnt_r, cnt_nxt;
  logic              honour_r, honour_nxt;
  logic              busy_r, busy_nxt;
  logic              done_r, done_nxt;
  logic [1:0]        cas_r, cas_nxt;
  aws_dec_s          dec;
  logic [31:0]       status;

  aws_wait_decode u_dec (
    .wait_reg_i (wait_r),
    .mem_reg_i  (mem_r),
    .req_i      (cycle_req_i),
    .dec_o      (dec)
  );

  assign status = {19'h0, cnt_r, 6'h0, pin_lvl_r, busy_r};

  // Register file and AXI4-Lite slave.
  always_comb begin
    wait_nxt    = wait_r;
    mem_nxt     = mem_r;
    aw_have_nxt = aw_have_r;
    aw_addr_nxt = aw_addr_r;
    w_have_nxt  = w_have_r;
    w_data_nxt  = w_data_r;
    w_strb_nxt  = w_strb_r;
    bvalid_nxt  = bvalid_r;
    bresp_nxt   = bresp_r;
    arready_nxt = arready_r;
    rvalid_nxt  = rvalid_r;
    rdata_nxt   = rdata_r;
    rresp_nxt   = rresp_r;
    if (awready_r && s_awvalid_i) begin
      aw_have_nxt = 1'b1;
      aw_addr_nxt = s_awaddr_i[AWS_AW-1:0];
    end
    if (wready_r && s_wvalid_i) begin
      w_have_nxt = 1'b1;
      w_data_nxt = s_wdata_i;
      w_strb_nxt = s_wstrb_i;
    end
    if (bvalid_r && s_bready_i) begin
      bvalid_nxt = 1'b0;
    end
    // Both halves are held until the response is free, so the order is irrelevant.
    if (aw_have_r && w_have_r && !bvalid_r) begin
      aw_have_nxt = 1'b0;
      w_have_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = AWS_RESP_OK;
      case (aw_addr_r)
        AWS_OFS_WAIT: begin
          if (w_strb_r[0]) begin
            wait_nxt[7:0] = w_data_r[7:0];
          end
          if (w_strb_r[1]) begin
            wait_nxt[15:8] = w_data_r[15:8];
          end
        end
        AWS_OFS_MEM: begin
          if (w_strb_r[0]) begin
            mem_nxt = w_data_r[1:0];
          end
        end
        AWS_OFS_STAT: bresp_nxt = AWS_RESP_OK;
        default: bresp_nxt = AWS_RESP_ERR;
      endcase
    end
    if (rvalid_r && s_rready_i) begin
      rvalid_nxt  = 1'b0;
      arready_nxt = 1'b1;
    end
    if (arready_r && s_arvalid_i) begin
      arready_nxt = 1'b0;
      rvalid_nxt  = 1'b1;
      rresp_nxt   = AWS_RESP_OK;
      case (s_araddr_i[AWS_AW-1:0])
        AWS_OFS_WAIT: rdata_nxt = {16'h0, wait_r};
        AWS_OFS_MEM:  rdata_nxt = {30'h0, mem_r};
        AWS_OFS_STAT: rdata_nxt = status;
        default: begin
          rdata_nxt = 32'h0;
          rresp_nxt = AWS_RESP_ERR;
        end
      endcase
    end
    // The read address channel opens on the first edge after reset, like the write side.
    arready_nxt = arready_nxt || (!arready_r && !rvalid_r);
    awready_nxt = !aw_have_nxt;
    wready_nxt  = !w_have_nxt;
  end

  // Only the power-on reset touches the registers; manual reset and standby do not.
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wait_r    <= AWS_WAIT_RST;
      mem_r     <= AWS_MEM_RST;
      aw_have_r <= 1'b0;
      aw_addr_r <= '0;
      w_have_r  <= 1'b0;
      w_data_r  <= 32'h0;
      w_strb_r  <= 4'h0;
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= AWS_RESP_OK;
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h0;
      rresp_r   <= AWS_RESP_OK;
    end else begin
      wait_r    <= wait_nxt;
      mem_r     <= mem_nxt;
      aw_have_r <= aw_have_nxt;
      aw_addr_r <= aw_addr_nxt;
      w_have_r  <= w_have_nxt;
      w_data_r  <= w_data_nxt;
      w_strb_r  <= w_strb_nxt;
      awready_r <= awready_nxt;
      wready_r  <= wready_nxt;
      bvalid_r  <= bvalid_nxt;
      bresp_r   <= bresp_nxt;
      arready_r <= arready_nxt;
      rvalid_r  <= rvalid_nxt;
      rdata_r   <= rdata_nxt;
      rresp_r   <= rresp_nxt;
    end
  end

  assign s_awready_o = awready_r;
  assign s_wready_o  = wready_r;
  assign s_bvalid_o  = bvalid_r;
  assign s_bresp_o   = bresp_r;
  assign s_arready_o = arready_r;
  assign s_rvalid_o  = rvalid_r;
  assign s_rdata_o   = rdata_r;
  assign s_rresp_o   = rresp_r;

  // The pin level only changes once the second and third stages agree.
  always_comb begin
    pin_lvl_nxt = pin_lvl_r;
    if (pin_s2_r == pin_s3_r) begin
      pin_lvl_nxt = pin_s3_r;
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pin_s1_r  <= 1'b0;
      pin_s2_r  <= 1'b0;
      pin_s3_r  <= 1'b0;
      pin_lvl_r <= 1'b0;
    end else begin
      pin_s1_r  <= ext_wait_i;
      pin_s2_r  <= pin_s1_r;
      pin_s3_r  <= pin_s2_r;
      pin_lvl_r <= pin_lvl_nxt;
    end
  end

  // Cycle sequencer: programmed states first, then the pin may stretch the cycle.
  always_comb begin
    st_nxt     = st_r;
    cnt_nxt    = cnt_r;
    honour_nxt = honour_r;
    busy_nxt   = busy_r;
    done_nxt   = 1'b0;
    cas_nxt    = cas_r;
    case (st_r)
      AWS_IDLE: begin
        if (cycle_start_i && !standby_i) begin
          st_nxt     = AWS_COUNT;
          cnt_nxt    = dec.len_m1;
          honour_nxt = dec.honour;
          cas_nxt    = dec.cas;
          busy_nxt   = 1'b1;
        end
      end
      AWS_COUNT: begin
        if (cnt_r != 5'h00) begin
          cnt_nxt = cnt_r - 5'h01;
        end else if (honour_r && pin_lvl_r) begin
          st_nxt = AWS_EXTEND;
        end else begin
          st_nxt   = AWS_IDLE;
          busy_nxt = 1'b0;
          done_nxt = 1'b1;
        end
      end
      AWS_EXTEND: begin
        if (!pin_lvl_r) begin
          st_nxt   = AWS_IDLE;
          busy_nxt = 1'b0;
          done_nxt = 1'b1;
        end
      end
      default: begin
        st_nxt   = AWS_IDLE;
        busy_nxt = 1'b0;
      end
    endcase
    // A manual reset aborts the cycle but keeps the programmed register.
    if (manual_rst_i) begin
      st_nxt   = AWS_IDLE;
      cnt_nxt  = 5'h00;
      busy_nxt = 1'b0;
      done_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_r     <= AWS_IDLE;
      cnt_r    <= 5'h00;
      honour_r <= 1'b0;
      busy_r   <= 1'b0;
      done_r   <= 1'b0;
      cas_r    <= 2'h0;
    end else begin
      st_r     <= st_nxt;
      cnt_r    <= cnt_nxt;
      honour_r <= honour_nxt;
      busy_r   <= busy_nxt;
      done_r   <= done_nxt;
      cas_r    <= cas_nxt;
    end
  end

  assign cycle_busy_o = busy_r;
  assign cycle_done_o = done_r;
  assign cas_code_o   = cas_r;

  a_wait_reset_value: assert property (
    @(posedge clk_sys_i) $rose(nrst_i) |-> wait_r == AWS_WAIT_RST)
    else $error("wait register not all ones after power-on reset");

  a_wait_keep_manual: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i)
    (manual_rst_i || standby_i) && !(aw_have_r && w_have_r && !bvalid_r)
    |=> $stable(wait_r))
    else $error("wait register changed on manual reset or standby");

  a_area6_first_len: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i || manual_rst_i)
    st_r == AWS_IDLE && cycle_start_i && !standby_i && cycle_req_i.area == 3'd6
    && !cycle_req_i.burst && wait_r[15:13] == 3'h5 |=> cnt_r == 5'd7 && honour_r && busy_r)
    else $error("area 6 code 5 does not load eight states");

  a_area5_ignore_pin: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i || manual_rst_i)
    st_r == AWS_IDLE && cycle_start_i && !standby_i && cycle_req_i.area == 3'd5
    && !cycle_req_i.burst && wait_r[12:10] == 3'h0 |=> !honour_r && cnt_r == 5'd1)
    else $error("area 5 code 0 honours the wait pin");

  a_burst_pitch: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i || manual_rst_i)
    st_r == AWS_IDLE && cycle_start_i && !standby_i && cycle_req_i.area == 3'd5
    && cycle_req_i.burst && wait_r[12:10] == 3'h2 |=> honour_r && cnt_r == 5'd2)
    else $error("area 5 burst beat pitch wrong");

  a_area4_len: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i || manual_rst_i)
    st_r == AWS_IDLE && cycle_start_i && !standby_i && cycle_req_i.area == 3'd4
    && wait_r[9:7] == 3'h7 |=> cnt_r == 5'd11 && honour_r)
    else $error("area 4 code 7 not ten waits");

  a_area3_dram_pin: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i || manual_rst_i)
    st_r == AWS_IDLE && cycle_start_i && !standby_i && cycle_req_i.area == 3'd3
    && mem_r[AWS_MEM_A3_BIT] |=> !honour_r && cas_r == $past(wait_r[6:5]))
    else $error("area 3 DRAM honours the wait pin");

  a_area12_cas: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i || manual_rst_i)
    st_r == AWS_IDLE && cycle_start_i && !standby_i && cycle_req_i.area == 3'd2
    && mem_r[AWS_MEM_A12_BIT] && wait_r[4:3] == 2'h1 |=> cnt_r == 5'd2 && !honour_r)
    else $error("area 2 DRAM CAS period wrong");

  a_pin_extends: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i || manual_rst_i)
    st_r == AWS_COUNT && cnt_r == 5'h00 && honour_r && pin_lvl_r
    |=> busy_r && !done_r && st_r == AWS_EXTEND)
    else $error("cycle ended while wait pin held");

  a_done_pulse: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i)
    done_r |-> !busy_r ##1 !done_r)
    else $error("done not a single pulse");
endmodule : aws_wait_ctrl
`default_nettype wire

// File: verif/aws_mem_model.sv
// Far-side memory model that stretches bus cycles through the wait pin.
`default_nettype none
module aws_mem_model (
  input  wire logic       clk_sys_i,
  input  wire logic       nrst_i,
  input  wire logic       busy_i,
  input  wire logic       arm_i,
  input  wire logic [7:0] hold_i,
  output logic            ext_wait_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] held_r;
  // The pin rises as soon as the model is armed, ahead of the cycle, so the synchroniser sees it.
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i)
      held_r <= 8'h00;
    else if (!arm_i)
      held_r <= 8'h00;
    else if (busy_i && held_r != 8'hff)
      held_r <= held_r + 8'h01;
  end
  assign ext_wait_o = arm_i && (held_r < hold_i);
endmodule : aws_mem_model
`default_nettype wire

// File: verif/aws_wait_ctrl_tb.sv
// Self-checking bench for the area wait-state controller.
`default_nettype none
module aws_wait_ctrl_tb
  import aws_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys_i = 1'b0, nrst_i = 1'b0, manual_rst_i = 1'b0, standby_i = 1'b0;
  logic [31:0] s_awaddr_i = 32'h0, s_wdata_i = 32'h0, s_araddr_i = 32'h0, s_rdata_o;
  logic [3:0]  s_wstrb_i = 4'h0;
  logic        s_awvalid_i = 1'b0, s_wvalid_i = 1'b0, s_bready_i = 1'b0;
  logic        s_arvalid_i = 1'b0, s_rready_i = 1'b0, cycle_start_i = 1'b0, arm = 1'b0;
  logic        s_awready_o, s_wready_o, s_bvalid_o, s_arready_o, s_rvalid_o;
  logic        cycle_busy_o, cycle_done_o, ext_wait_i;
  logic [1:0]  s_bresp_o, s_rresp_o, cas_code_o;
  aws_req_s    cycle_req_i = '0;
  logic [7:0]  hold = 8'h10;
  logic [31:0] seed = 32'h1346;
  logic [33:0] q_rd[$];
  logic [1:0]  q_b[$];
  int          q_lo[$], q_hi[$];
  int          bad_count = 0, n_checks = 0, run_len = 0, lo, hi;

  aws_wait_ctrl aws_wait_ctrl_inst (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
    .manual_rst_i(manual_rst_i), .standby_i(standby_i), .s_awaddr_i(s_awaddr_i),
    .s_awvalid_i(s_awvalid_i), .s_awready_o(s_awready_o), .s_wdata_i(s_wdata_i),
    .s_wstrb_i(s_wstrb_i), .s_wvalid_i(s_wvalid_i), .s_wready_o(s_wready_o),
    .s_bresp_o(s_bresp_o), .s_bvalid_o(s_bvalid_o), .s_bready_i(s_bready_i),
    .s_araddr_i(s_araddr_i), .s_arvalid_i(s_arvalid_i), .s_arready_o(s_arready_o),
    .s_rdata_o(s_rdata_o), .s_rresp_o(s_rresp_o), .s_rvalid_o(s_rvalid_o),
    .s_rready_i(s_rready_i), .cycle_start_i(cycle_start_i), .cycle_req_i(cycle_req_i),
    .ext_wait_i(ext_wait_i), .cycle_busy_o(cycle_busy_o), .cycle_done_o(cycle_done_o),
    .cas_code_o(cas_code_o));
  aws_mem_model aws_mem_model_inst (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
    .busy_i(cycle_busy_o), .arm_i(arm), .hold_i(hold), .ext_wait_o(ext_wait_i));

  initial begin
    forever #25 clk_sys_i = ~clk_sys_i;
  end

  function logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  function automatic logic [31:0] mkw(int c);
    logic [2:0] k;
    k = c[2:0];
    return {16'h0, k, k, k, k[1:0], k[1:0], k};
  endfunction : mkw

  function automatic bit dram(int a, int m);
    return a == 3 && m[0] || (a == 1 || a == 2) && m[1];
  endfunction : dram

  function automatic int exp_len(int a, int b, int c, int m);
    int ft[8] = '{0, 1, 2, 3, 4, 6, 8, 10};
    int bt[8] = '{2, 2, 3, 4, 4, 6, 8, 10};
    int ct[4] = '{1, 1, 2, 3};
    if (b != 0 && (a == 0 || a == 5 || a == 6)) return bt[c];
    if (a == 0 || a >= 4 && a <= 6) return 2 + ft[c];
    if (dram(a, m)) return 2 + ct[c % 4];
    if (a >= 1 && a <= 3) return 2 + c % 4;
    return 2;
  endfunction : exp_len

  task automatic chk(string what, logic [33:0] exp, logic [33:0] got);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude

  task automatic timeout(string what);
    bad_count++;
    $display("CHECK FAILED %s expected answer seen none", what);
    conclude();
  endtask : timeout

  // The monitor samples at the edge, so it sees the values the handshake was judged on.
  always @(posedge clk_sys_i) begin
    if (s_rvalid_o === 1'b1 && s_rready_i)
      chk("read", q_rd.pop_front(), {s_rresp_o, s_rdata_o});
    if (s_bvalid_o === 1'b1 && s_bready_i)
      chk("bresp", {32'h0, q_b.pop_front()}, {32'h0, s_bresp_o});
    if (cycle_busy_o === 1'b1)
      run_len++;
    if (cycle_done_o === 1'b1) begin
      lo = q_lo.pop_front();
      hi = q_hi.pop_front();
      n_checks++;
      if (run_len < lo || run_len > hi) begin
        bad_count++;
        $display("CHECK FAILED cycle_len expected %0d..%0d seen %0d", lo, hi, run_len);
      end
      run_len = 0;
    end
  end

  task automatic axi_wr(logic [31:0] a, logic [31:0] d, logic [3:0] st, logic [1:0] er);
    int t;
    @(posedge clk_sys_i);
    q_b.push_back(er);
    s_awaddr_i <= a;
    s_wdata_i <= d;
    s_wstrb_i <= st;
    s_awvalid_i <= 1'b1;
    s_wvalid_i <= 1'b1;
    s_bready_i <= 1'b1;
    for (t = 0; t < 50; t++) begin
      @(posedge clk_sys_i);
      if (s_awready_o === 1'b1) s_awvalid_i <= 1'b0;
      if (s_wready_o === 1'b1) s_wvalid_i <= 1'b0;
      if (s_bvalid_o === 1'b1) break;
    end
    s_bready_i <= 1'b0;
    if (t == 50) timeout("write");
  endtask : axi_wr

  task automatic axi_rd(logic [31:0] a, logic [33:0] exp);
    int t;
    @(posedge clk_sys_i);
    q_rd.push_back(exp);
    s_araddr_i <= a;
    s_arvalid_i <= 1'b1;
    s_rready_i <= 1'b1;
    for (t = 0; t < 50; t++) begin
      @(posedge clk_sys_i);
      if (s_arready_o === 1'b1) s_arvalid_i <= 1'b0;
      if (s_rvalid_o === 1'b1) break;
    end
    s_rready_i <= 1'b0;
    if (t == 50) timeout("read");
  endtask : axi_rd

  task automatic run(int a, int b, int l, int h);
    int t;
    @(posedge clk_sys_i);
    q_lo.push_back(l);
    q_hi.push_back(h);
    cycle_req_i <= '{area: a[2:0], burst: b[0]};
    cycle_start_i <= 1'b1;
    @(posedge clk_sys_i);
    cycle_start_i <= 1'b0;
    for (t = 0; t < 300; t++) begin
      @(posedge clk_sys_i);
      if (cycle_done_o === 1'b1) break;
    end
    if (t == 300) timeout("cycle_done");
  endtask : run

  initial begin
    int m, c, a, b, l, tc;
    static int pin_tc[10] = '{'h6000, 'h6100, 'h5010, 'h4000, 'h4010, 'h3010, 'h3011, 'h2010,
                       'h2012, 'h0100};
    logic [31:0] r;
    repeat (3) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    @(posedge clk_sys_i);
    axi_rd(32'h0, 34'h0ffff);
    axi_wr(32'hc, 32'h1234, 4'hf, AWS_RESP_ERR);
    axi_rd(32'hc, {AWS_RESP_ERR, 32'h0});
    axi_rd(32'h8, 34'h0);
    axi_rd(32'h0, 34'h0ffff);
    for (m = 0; m < 4; m += 3) begin
      axi_wr(32'h4, m, 4'h1, AWS_RESP_OK);
      axi_rd(32'h4, 34'(m));
      for (c = 0; c < 8; c++) begin
        axi_wr(32'h0, mkw(c), 4'h3, AWS_RESP_OK);
        axi_rd(32'h0, {2'h0, mkw(c)});
        for (a = 0; a < 8; a++)
          for (b = 0; b < 2; b++) begin
            l = exp_len(a, b, c, m);
            run(a, b, l, l);
            if (a >= 1 && a <= 3)
              chk("cas_code", 34'(dram(a, m) ? c % 4 : 0), 34'(cas_code_o));
          end
      end
    end
    // Pin cases are armed well ahead so the three-stage synchroniser has settled.
    foreach (pin_tc[i]) begin
      tc = pin_tc[i];
      a = (tc >> 12) & 7;
      b = (tc >> 8) & 1;
      c = (tc >> 4) & 15;
      m = tc & 15;
      axi_wr(32'h4, m, 4'h1, AWS_RESP_OK);
      axi_wr(32'h0, mkw(c), 4'h3, AWS_RESP_OK);
      r = xs();
      hold <= 8'h10 + {5'h0, r[2:0]};
      arm <= 1'b1;
      repeat (6) @(posedge clk_sys_i);
      l = exp_len(a, b, c, m);
      if (b != 0 || !dram(a, m) && c != 0)
        run(a, b, hold, hold + 7);
      else
        run(a, b, l, l);
      arm <= 1'b0;
    end
    r = xs();
    axi_wr(32'h0, 32'h0, 4'h3, AWS_RESP_OK);
    axi_wr(32'h0, r, 4'h2, AWS_RESP_OK);
    axi_rd(32'h0, {18'h0, r[15:8], 8'h00});
    manual_rst_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    manual_rst_i <= 1'b0;
    axi_rd(32'h0, {18'h0, r[15:8], 8'h00});
    standby_i <= 1'b1;
    @(posedge clk_sys_i);
    cycle_start_i <= 1'b1;
    @(posedge clk_sys_i);
    cycle_start_i <= 1'b0;
    repeat (20) @(posedge clk_sys_i);
    chk("busy_in_standby", 34'h0, {33'h0, cycle_busy_o});
    axi_rd(32'h0, {18'h0, r[15:8], 8'h00});
    standby_i <= 1'b0;
    @(posedge clk_sys_i);
    nrst_i <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    @(posedge clk_sys_i);
    axi_rd(32'h0, 34'h0ffff);
    repeat (2) @(posedge clk_sys_i);
    conclude();
  end
endmodule : aws_wait_ctrl_tb
`default_nettype wire
